// File: hw/game_port_defines.svh
// Register indices, field positions, reset values and timing counts for the game port input block.
// Assumes inclusion by bare name from the design module.
`ifndef GAME_PORT_DEFINES_SVH
`define GAME_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices on the plain register port
// ----------------------------------------------------------------
`define GP_REG_LEFT_MOTION   4'h0
`define GP_REG_RIGHT_MOTION  4'h1
`define GP_REG_LEFT_POT      4'h2
`define GP_REG_RIGHT_POT     4'h3
`define GP_REG_POT_START     4'h4
`define GP_REG_INPUT_STATUS  4'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GP_POT_START_BIT     0
`define GP_STAT_POT_LSB      0
`define GP_STAT_FIRE_LSB     6
`define GP_STAT_BUSY_BIT     8

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define GP_COUNT_RESET       8'h00
`define GP_READ_IDLE         16'h0000
`define GP_POT_RESET_LINES   8

`endif

// File: hw/game_port_pkg.sv
// Types shared by the game port input block: pin carriers and the pot measurement states.
// Assumes nothing beyond a SystemVerilog compiler.
package game_port_pkg;

   // Quadrature pins of one port; all active low as they arrive at the connector.
   typedef struct packed {
      logic vert_phase_a;
      logic vertical_phase_b_input;
      logic horiz_phase_a;
      logic horizontal_phase_b_input;
   } quad_pins_s;

   // Every asynchronous pin the block samples, port 1 in the upper entries.
   typedef struct packed {
      quad_pins_s [1:0] quad;
      logic [1:0]       fire_n;
      logic [3:0]       pot_high;
   } pin_in_s;

   typedef enum logic [1:0] {
      POT_IDLE,
      POT_DUMP,
      POT_CHARGE
   } pot_state_e;

endpackage : game_port_pkg

// File: hw/game_port_input_counters.sv
// Game port input logic for two controller ports: quadrature motion counters, switch states and pot counters.
// Assumes pins arrive asynchronously, line_tick is a one-cycle pulse per horizontal scan line on clk,
// and pot_high comes from external threshold comparators on the timing capacitors.
`include "game_port_defines.svh"

module game_port_input_counters #(
   parameter int unsigned POT_RESET_LINES = `GP_POT_RESET_LINES
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Register port
   input  wire logic [3:0]            addr,
   input  wire logic [15:0]           wdata,
   input  wire logic                  wr,
   input  wire logic                  rd,
   output logic      [15:0]           rdata,
   // Connector pins and video timing
   input  game_port_pkg::pin_in_s     pins,
   input  wire logic                  line_tick,
   // Outputs to the analog front end and peripheral port
   output logic      [3:0]            pot_discharge,
   output logic      [1:0]            fire_bits,
   output logic                       light_pen_trigger
);
   import game_port_pkg::*;

   localparam int PW = $bits(pin_in_s);
   localparam int LW = $clog2(POT_RESET_LINES + 1);

   initial
   begin
      if (POT_RESET_LINES < 1 || POT_RESET_LINES > 255)
      begin
         $error("POT_RESET_LINES out of range");
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // A bit only moves once the second and third stages agree, which also rejects single-cycle glitches.
   logic [PW-1:0] sync1;
   logic [PW-1:0] sync2;
   logic [PW-1:0] sync3;
   logic [PW-1:0] filt;
   pin_in_s       clean;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1 <= '1;
         sync2 <= '1;
         sync3 <= '1;
         filt  <= '1;
      end
      else
      begin
         sync1 <= pins;
         sync2 <= sync1;
         sync3 <= sync2;
         filt  <= (sync3 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
      end
   end

   assign clean = pin_in_s'(filt);

   // ----------------------------------------------------------------
   // Quadrature decode
   // ----------------------------------------------------------------
   // The two low counter bits are the phase position in true sense, so the switch levels show through.
   function automatic logic [1:0] phase_code(input logic a_n, input logic b_n);
      phase_code = {~b_n, a_n ^ b_n};
   endfunction : phase_code

   function automatic logic [7:0] step_count(input logic [7:0] cnt, input logic [1:0] code);
      if (code == cnt[1:0] + 2'd1)
      begin
         step_count = cnt + 8'd1;
      end
      else if (code == cnt[1:0] - 2'd1)
      begin
         step_count = cnt - 8'd1;
      end
      else
      begin
         step_count = {cnt[7:2], code};
      end
   endfunction : step_count

   logic [7:0] vert_count [2];
   logic [7:0] horiz_count [2];
   logic       primed;

   // The first cycle after reset only adopts the filter's reset phase (code 0), so a resting mouse at another phase still steps once its pins come through.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         primed         <= 1'b0;
         vert_count[0]  <= `GP_COUNT_RESET;
         vert_count[1]  <= `GP_COUNT_RESET;
         horiz_count[0] <= `GP_COUNT_RESET;
         horiz_count[1] <= `GP_COUNT_RESET;
      end
      else
      begin
         primed <= 1'b1;
         for (int p = 0; p < 2; p++)
         begin
            if (!primed)
            begin
               vert_count[p]  <= {6'h00, phase_code(clean.quad[p].vert_phase_a,
                                                    clean.quad[p].vertical_phase_b_input)};
               horiz_count[p] <= {6'h00, phase_code(clean.quad[p].horiz_phase_a,
                                                    clean.quad[p].horizontal_phase_b_input)};
            end
            else
            begin
               vert_count[p]  <= step_count(vert_count[p], phase_code(clean.quad[p].vert_phase_a,
                                            clean.quad[p].vertical_phase_b_input));
               horiz_count[p] <= step_count(horiz_count[p], phase_code(clean.quad[p].horiz_phase_a,
                                            clean.quad[p].horizontal_phase_b_input));
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Pot measurement sequencer
   // ----------------------------------------------------------------
   pot_state_e     pot_state;
   logic [LW-1:0]  dump_lines;
   logic           pot_start;
   logic           dump_last;
   logic [7:0]     pot_count [4];
   logic [3:0]     pot_done;

   assign pot_start = wr && (addr == `GP_REG_POT_START) && wdata[`GP_POT_START_BIT];
   assign dump_last = (pot_state == POT_DUMP) && line_tick && (dump_lines == LW'(POT_RESET_LINES - 1));

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pot_state     <= POT_IDLE;
         dump_lines    <= '0;
         pot_discharge <= 4'h0;
      end
      else
      begin
         case (pot_state)
            POT_IDLE, POT_CHARGE:
            begin
               if (pot_start)
               begin
                  pot_state     <= POT_DUMP;
                  dump_lines    <= '0;
                  pot_discharge <= 4'hf;
               end
            end
            POT_DUMP:
            begin
               if (pot_start)
               begin
                  dump_lines <= '0;
               end
               else if (dump_last)
               begin
                  pot_state     <= POT_CHARGE;
                  pot_discharge <= 4'h0;
               end
               else if (line_tick)
               begin
                  dump_lines <= dump_lines + LW'(1);
               end
            end
            default:
            begin
               pot_state     <= POT_IDLE;
               pot_discharge <= 4'h0;
            end
         endcase
      end
   end

   // Index order: left X, left Y, right X, right Y.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pot_done <= 4'h0;
         for (int i = 0; i < 4; i++)
         begin
            pot_count[i] <= `GP_COUNT_RESET;
         end
      end
      else if (pot_start)
      begin
         pot_done <= 4'h0;
         for (int i = 0; i < 4; i++)
         begin
            pot_count[i] <= `GP_COUNT_RESET;
         end
      end
      else if (pot_state == POT_CHARGE && line_tick)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (pot_done[i] || clean.pot_high[i])
            begin
               pot_done[i] <= 1'b1;
            end
            else
            begin
               pot_count[i] <= pot_count[i] + 8'd1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   // Pot pin levels are readable so a second or third button on a pot line can be sensed.
   logic [15:0] read_word;

   always_comb
   begin
      read_word = `GP_READ_IDLE;
      case (addr)
         `GP_REG_LEFT_MOTION:  read_word = {vert_count[0], horiz_count[0]};
         `GP_REG_RIGHT_MOTION: read_word = {vert_count[1], horiz_count[1]};
         `GP_REG_LEFT_POT:     read_word = {pot_count[1], pot_count[0]};
         `GP_REG_RIGHT_POT:    read_word = {pot_count[3], pot_count[2]};
         `GP_REG_INPUT_STATUS:
         begin
            read_word[`GP_STAT_POT_LSB +: 4]  = clean.pot_high;
            read_word[`GP_STAT_FIRE_LSB +: 2] = clean.fire_n;
            read_word[`GP_STAT_BUSY_BIT]      = (pot_state == POT_DUMP);
         end
         default:              read_word = `GP_READ_IDLE;
      endcase
   end

   // Read data stand for exactly the cycle after the strobe, zero otherwise.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata <= `GP_READ_IDLE;
      end
      else
      begin
         rdata <= rd ? read_word : `GP_READ_IDLE;
      end
   end

   // ----------------------------------------------------------------
   // Peripheral fire bits and light pen trigger
   // ----------------------------------------------------------------
   // Fire buttons arrive on their own fire_n pins and appear as fire_bits and as status bits 6 and 7.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         fire_bits         <= 2'b11;
         light_pen_trigger <= 1'b0;
      end
      else
      begin
         fire_bits         <= clean.fire_n;
         light_pen_trigger <= ~clean.fire_n[0];
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_start_clears_pots: assert property (@(posedge clk) disable iff (rst)
      pot_start |=> (pot_count[0] == 8'h00) && (pot_count[3] == 8'h00) && (pot_state == POT_DUMP))
      else $error("pot start did not clear counters");

   a_dump_discharge: assert property (@(posedge clk) disable iff (rst)
      (pot_state == POT_DUMP) |-> (pot_discharge == 4'hf) && (pot_count[0] == 8'h00))
      else $error("capacitors not held during dump");

   a_pot_count_step: assert property (@(posedge clk) disable iff (rst)
      (pot_state == POT_CHARGE && line_tick && !pot_start && !pot_done[0] && !clean.pot_high[0])
      |=> pot_count[0] == $past(pot_count[0]) + 8'd1)
      else $error("pot counter missed a line");

   a_pot_count_hold: assert property (@(posedge clk) disable iff (rst)
      (pot_done[2] && !pot_start) |=> $stable(pot_count[2]) && pot_done[2])
      else $error("pot counter moved after threshold");

   a_pot_wraps: assert property (@(posedge clk) disable iff (rst)
      (pot_state == POT_CHARGE && line_tick && !pot_start && !pot_done[3] && !clean.pot_high[3]
       && pot_count[3] == 8'hff) |=> pot_count[3] == 8'h00)
      else $error("pot counter did not wrap");

   a_motion_wraps: assert property (@(posedge clk) disable iff (rst)
      (primed && horiz_count[0] == 8'hff && phase_code(clean.quad[0].horiz_phase_a,
       clean.quad[0].horizontal_phase_b_input) == 2'b00) |=> horiz_count[0] == 8'h00)
      else $error("motion counter did not wrap up");

   a_switch_bits: assert property (@(posedge clk) disable iff (rst)
      primed |=> (horiz_count[1][1] == !$past(clean.quad[1].horizontal_phase_b_input))
                 && (vert_count[1][1] == !$past(clean.quad[1].vertical_phase_b_input)))
      else $error("switch bits do not follow pins");

   a_read_latency: assert property (@(posedge clk) disable iff (rst)
      (rd && addr == `GP_REG_RIGHT_POT) |=> rdata == {$past(pot_count[3]), $past(pot_count[2])})
      else $error("pot read data wrong or late");

   a_read_idle: assert property (@(posedge clk) disable iff (rst)
      (!rd || addr > `GP_REG_INPUT_STATUS) |=> rdata == 16'h0000)
      else $error("read data outside read slot");

   a_fire_sense: assert property (@(posedge clk) disable iff (rst)
      ##1 fire_bits == $past(clean.fire_n) && light_pen_trigger == !$past(clean.fire_n[0]))
      else $error("fire bits not open-high");

endmodule : game_port_input_counters

// File: verif/game_port_controllers.sv
// Behavioural model of the controllers on both ports: switches, mouse phases and pot capacitors.
// Assumes the bench sets switch closures and pot charge times; the pins follow at once.
module game_port_controllers
(
   // Clock and video timing
   input  wire logic               clk,
   input  wire logic               line_tick,
   // Closures set by the bench, 1 = closed
   input  wire logic [1:0]         sw_fwd,
   input  wire logic [1:0]         sw_back,
   input  wire logic [1:0]         sw_left,
   input  wire logic [1:0]         sw_right,
   input  wire logic [1:0]         fire_closed,
   // Scan lines of charge each pot needs before it crosses the threshold
   input  wire logic [3:0][9:0]    pot_need,
   // Device side
   input  wire logic [3:0]         pot_discharge,
   output game_port_pkg::pin_in_s  pins
);
   import game_port_pkg::*;

   logic [3:0][9:0] charge;

   // -----------------------------------------------------------
   // Capacitors
   // -----------------------------------------------------------
   // Charge starts full so the lines sit above threshold until the first dump.
   initial charge = {4{10'h3ff}};

   always @(posedge clk)
   begin
      for (int g = 0; g < 4; g++)
      begin
         if (pot_discharge[g])
            charge[g] <= 10'h000;
         else if (line_tick && charge[g] != 10'h3ff)
            charge[g] <= charge[g] + 10'h001;
      end
   end

   // -----------------------------------------------------------
   // Pins
   // -----------------------------------------------------------
   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         pins.quad[p].vert_phase_a             = ~sw_fwd[p];
         pins.quad[p].vertical_phase_b_input   = ~sw_left[p];
         pins.quad[p].horiz_phase_a            = ~sw_back[p];
         pins.quad[p].horizontal_phase_b_input = ~sw_right[p];
      end
      pins.fire_n = ~fire_closed;
      for (int g = 0; g < 4; g++)
         pins.pot_high[g] = !pot_discharge[g] && charge[g] >= pot_need[g];
   end
endmodule : game_port_controllers

// File: verif/game_port_input_counters_tb_top.sv
// Self-checking bench for the game port input block with its controller model.
// Assumes the design's package and defines header are compiled first.
module game_port_input_counters_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import game_port_pkg::*;

   localparam int unsigned LINES = 2;

   logic            clk, rst, wr, rd, line_tick, light_pen_trigger;
   logic [3:0]      addr, pot_discharge, tcnt;
   logic [15:0]     wdata, rdata, v;
   logic [1:0]      fire_bits, sw_fwd, sw_back, sw_left, sw_right, fire_closed;
   logic [3:0][9:0] pot_need;
   pin_in_s         pins;
   int              n_mismatch, cmp_count, n;
   int              cur [2][2];

   game_port_input_counters #(.POT_RESET_LINES(LINES)) game_port_input_counters_i (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .pins(pins), .line_tick(line_tick), .pot_discharge(pot_discharge), .fire_bits(fire_bits),
      .light_pen_trigger(light_pen_trigger));

   game_port_controllers game_port_controllers_i (
      .clk(clk), .line_tick(line_tick), .sw_fwd(sw_fwd), .sw_back(sw_back), .sw_left(sw_left),
      .sw_right(sw_right), .fire_closed(fire_closed), .pot_need(pot_need),
      .pot_discharge(pot_discharge), .pins(pins));

   // -----------------------------------------------------------
   // Clock, scan lines and watchdog
   // -----------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         tcnt      <= 4'h0;
         line_tick <= 1'b0;
      end
      else
      begin
         tcnt      <= tcnt + 4'h1;
         line_tick <= (tcnt == 4'hf);
      end
   end

   initial
   begin
      #800000;
      n_mismatch++;
      $display("BAD %0t watchdog expired", $time);
      close_out();
   end

   // -----------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rreg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg

   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg

   // Steps one axis through its phase code; one pin changes per step.
   task automatic move(input int p, input int ax, input int steps, input int dir);
      logic [1:0] c;
      repeat (steps)
      begin
         cur[p][ax] = (cur[p][ax] + dir) & 3;
         c = cur[p][ax][1:0];
         @(posedge clk);
         if (ax == 0)
         begin
            sw_right[p] <= c[1];
            sw_back[p]  <= c[1] ^ c[0];
         end
         else
         begin
            sw_left[p] <= c[1];
            sw_fwd[p]  <= c[1] ^ c[0];
         end
         repeat (8) @(posedge clk);
      end
   endtask : move

   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   task automatic t_reset();
      for (int a = 0; a < 4; a++)
      begin
         rreg(a[3:0], v);
         chk(v, 16'h0000, "reset value");
      end
      rreg(4'h7, v);
      chk(v, 16'h0000, "unmapped read");
      @(posedge clk);
      #1 chk(rdata, 16'h0000, "read data after its cycle");
      $display("test reset done");
   endtask : t_reset

   task automatic t_motion();
      move(0, 0, 3, -1);
      rreg(4'h0, v);
      chk(v, 16'h00fd, "left wrap down");
      move(0, 0, 5, 1);
      rreg(4'h0, v);
      chk(v, 16'h0002, "left count up");
      move(1, 1, 6, 1);
      rreg(4'h1, v);
      chk(v, 16'h0600, "right vertical");
      rreg(4'h0, v);
      chk(v, 16'h0002, "left untouched");
      $display("test motion done");
   endtask : t_motion

   task automatic t_joystick();
      @(posedge clk);
      sw_back[0] <= 1'b0;
      repeat (8) @(posedge clk);
      rreg(4'h0, v);
      chk({14'h0, v[1], v[1] ^ v[0]}, 16'h0002, "right and back");
      rreg(4'h1, v);
      chk({14'h0, v[9], v[9] ^ v[8]}, 16'h0003, "left and forward");
      $display("test joystick done");
   endtask : t_joystick

   task automatic t_fire();
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         fire_closed <= i[1:0];
         repeat (8) @(posedge clk);
         #1 chk({14'h0, fire_bits}, {14'h0, ~i[1:0]}, "fire bits");
         chk({15'h0, light_pen_trigger}, {15'h0, i[0]}, "pen trigger");
         rreg(4'h5, v);
         chk({14'h0, v[7:6]}, {14'h0, ~i[1:0]}, "status fire");
      end
      $display("test fire done");
   endtask : t_fire

   task automatic t_pot();
      // Start just after a scan line so the dump count below sees every line.
      @(posedge clk iff line_tick);
      pot_need <= {10'd258, 10'd0, 10'd1, 10'd5};
      wreg(4'h4, 16'h0001);
      #1 chk({12'h0, pot_discharge}, 16'h000f, "dump on start");
      rreg(4'h2, v);
      chk(v, 16'h0000, "counts cleared");
      repeat (4) @(posedge clk);
      rreg(4'h5, v);
      chk(v, 16'h0100, "status during dump");
      n = 0;
      while (pot_discharge === 4'hf && n < 20)
      begin
         @(posedge clk iff line_tick);
         n++;
         repeat (2) @(posedge clk);
         #1;
      end
      chk(16'(n), 16'(LINES), "dump lines");
      repeat (262) @(posedge clk iff line_tick);
      rreg(4'h2, v);
      chk(v, 16'h0105, "left pots");
      rreg(4'h3, v);
      chk(v, 16'h0200, "right pots");
      rreg(4'h5, v);
      chk(v, 16'h000f, "status after charge");
      wreg(4'h4, 16'h0000);
      wreg(4'h0, 16'h0001);
      rreg(4'h2, v);
      chk(v, 16'h0105, "ignored writes");
      wreg(4'h4, 16'h0001);
      rreg(4'h2, v);
      chk(v, 16'h0000, "restart clears");
      $display("test pot done");
   endtask : t_pot

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out

   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      {wr, rd, addr, wdata} = '0;
      {sw_fwd, sw_back, sw_left, sw_right, fire_closed} = '0;
      pot_need = '0;
      cur = '{default: 0};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_motion();
      t_joystick();
      t_fire();
      t_pot();
      close_out();
   end
endmodule : game_port_input_counters_tb_top
